// ==== design/ict_cfg.svh ====
`ifndef ICT_CFG_SVH
`define ICT_CFG_SVH
// ---------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ---------------------------------------------------------------
`define ICT_IDX_CTL0 12'h04d6
`define ICT_IDX_CTL1 12'h04d7
`define ICT_IDX_VTB 12'h045d
`define ICT_IDX_FLAG 12'h04a0
`define ICT_IDX_ENA 12'h04a1
`define ICT_IDX_PRIO 12'h04a2
`define ICT_IDX_MODE 12'h04a3
// ---------------------------------------------------------------
// Field positions in interrupt_control_0; MVEC is bit 0 of the mode register
// ---------------------------------------------------------------
`define ICT_BIT_GH 7
`define ICT_BIT_GL 6
`define ICT_BIT_PLE 5
`define ICT_BIT_MVEC 0
// ---------------------------------------------------------------
// Reset values and fixed branch addresses
// ---------------------------------------------------------------
`define ICT_RST_EDGE 3'h7
`define ICT_RST_VTB 21'h00_0008
`define ICT_RST_MVEC 1'h1
`define ICT_FIXED_HIGH 21'h00_0008
`define ICT_FIXED_LOW 21'h00_0018
`endif

// ==== design/ict_pkg.sv ====
package ict_pkg;
   // Nesting state, codes equal to the status field
   typedef enum logic [1:0] {
      ICT_MAIN = 2'b00,
      ICT_LOW = 2'b01,
      ICT_HIGH = 2'b10,
      ICT_HIGH_OVER_LOW = 2'b11
   } ict_nest_t;
endpackage : ict_pkg

// ==== design/ict_edge_det.sv ====
`timescale 1ns/1ps
module ict_edge_det #(
   parameter int N = 3
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [N-1:0] i_pin,
   input wire logic [N-1:0] i_rise_sel,
   output logic [N-1:0] o_edge
);
   // Startup blanking: no edge until the sample pair is real
   logic [2:0] prime;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prime <= 3'h0;
      end else begin
         prime <= {prime[1:0], 1'b1};
      end
   end

   // ---------------------------------------------------------------
   // Per pin: two-stage synchroniser, then a compare stage
   // ---------------------------------------------------------------
   for (genvar g = 0; g < N; g++) begin : g_pin
      logic sync1;
      logic sync2;
      logic prev;
      // Only sync2 reads sync1, the edge test reads sync2 and prev
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
         end else begin
            sync1 <= i_pin[g];
            sync2 <= sync1;
            prev <= sync2;
         end
      end
      // Polarity select: 1 rising, 0 falling
      assign o_edge[g] = prime[2] &
         (i_rise_sel[g] ? (sync2 & ~prev) : (~sync2 & prev));
   end
endmodule : ict_edge_det

// ==== design/ict_prio_pick.sv ====
`timescale 1ns/1ps
module ict_prio_pick #(
   parameter int N = 8
) (
   input wire logic [N-1:0] i_req,
   output logic o_any,
   output logic [4:0] o_idx
);
   // Lowest numbered request wins inside one priority level
   always_comb begin
      o_idx = 5'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (i_req[i]) begin
            o_idx = 5'(i);
         end
      end
   end

   assign o_any = |i_req;
endmodule : ict_prio_pick

// ==== design/ict_top.sv ====
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "ict_cfg.svh"
// Summary of operation
// - After reset all sources sit at high priority until software changes them.
// - Vector table base resets to 0x000008.
// - External inputs are edge triggered, select 1 rising, 0 falling.
// - A selected edge sets the input flag; its enable gates the request.
// - Enabled external inputs wake the processor from idle or sleep.
// - After wake, vectoring happens only with global high enable set.
// - External input priority follows its own priority select bit.
// - Every enabled pending event raises the wake request in any mode.
// - Wake ignores global enables and needs no clock edge.
// - Without the vector table, table vectoring and its priority vanish.
// - Without table and levels, every interrupt branches to 0008h.
// - Levels off: global enable passes unmasked interrupts, clear blocks all.
// - Levels on: global high passes high ones, also needed for low.
// - Levels on: global low gates low ones; levels off: reads zero.
// - Priority levels enable gives two levels; off treats all as high.
// - Nesting field reports main, low, high, or high over low.
// - Vectored mode: entry address is table base plus vector number.
// - Pending high requests are always served before low ones.
module ict_top
   import ict_pkg::*;
#(
   parameter int NSRC = 8
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [13:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic [2:0] I_EXT_IRQ_PIN,
   input wire logic [NSRC-1:0] I_SRC_EVENT,
   input wire logic I_CPU_ENTER,
   input wire logic I_CPU_RETURN,
   output logic O_IRQ_HIGH,
   output logic O_IRQ_LOW,
   output logic [4:0] O_VECTOR_NUM,
   output logic [20:0] O_VECTOR_ADDR,
   output logic O_WAKE
);
   localparam int NEXT = 3;

   // Flags, enables and priorities must fit one bus word
   if (NSRC < NEXT || NSRC > 32) begin : g_bad_nsrc
      $error("ict_top: NSRC must lie between 3 and 32");
   end

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic gh;
   logic gl;
   logic ple;
   logic mvec;
   logic [2:0] edge_sel;
   logic [20:0] vtb;
   logic [NSRC-1:0] flag;
   logic [NSRC-1:0] ena;
   logic [NSRC-1:0] prio;
   ict_nest_t nest;
   ict_nest_t next_nest;

   // ---------------------------------------------------------------
   // Wishbone decode
   // ---------------------------------------------------------------
   wire wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   wire wr = I_WB_CYC & I_WB_STB & I_WB_WE & O_WB_ACK; // Commit at ack
   wire [11:0] idx = I_WB_ADR[13:2];
   wire hit_ctl0 = (idx == `ICT_IDX_CTL0);
   wire hit_ctl1 = (idx == `ICT_IDX_CTL1);
   wire hit_vtb = (idx == `ICT_IDX_VTB);
   wire hit_flag = (idx == `ICT_IDX_FLAG);
   wire hit_ena = (idx == `ICT_IDX_ENA);
   wire hit_prio = (idx == `ICT_IDX_PRIO);
   wire hit_mode = (idx == `ICT_IDX_MODE);
   wire wr_ctl0 = wr & hit_ctl0 & I_WB_SEL[0];
   wire wr_mode = wr & hit_mode & I_WB_SEL[0];
   wire wr_vtb = wr & hit_vtb;
   wire wr_flag = wr & hit_flag;
   wire wr_ena = wr & hit_ena;
   wire wr_prio = wr & hit_prio;

   // Byte lane mask so partial writes leave other lanes alone
   wire [31:0] lane = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                       {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
   wire [31:0] w_vtb = (I_WB_DAT & lane) | ({11'h0, vtb} & ~lane);
   wire [31:0] w_ena = (I_WB_DAT & lane) |
                       ({{(32-NSRC){1'b0}}, ena} & ~lane);
   wire [31:0] w_prio = (I_WB_DAT & lane) |
                        ({{(32-NSRC){1'b0}}, prio} & ~lane);
   wire [31:0] w_clr = I_WB_DAT & lane;

   // Low enable hides behind levels enable when read
   wire [7:0] rd_ctl0 = {gh, gl & ple, ple, 2'b00, edge_sel};
   wire [7:0] rd_ctl1 = {nest, 6'b00_0000};
   wire [31:0] rdata =
      hit_ctl0 ? {24'h00_0000, rd_ctl0} :
      hit_ctl1 ? {24'h00_0000, rd_ctl1} :
      hit_vtb ? {11'h000, vtb} :
      hit_flag ? {{(32-NSRC){1'b0}}, flag} :
      hit_ena ? {{(32-NSRC){1'b0}}, ena} :
      hit_prio ? {{(32-NSRC){1'b0}}, prio} :
      hit_mode ? {31'h0000_0000, mvec} :
      32'h0000_0000;

   // One wait state answer; unmapped reads give zero
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
      end else begin
         O_WB_ACK <= wb_req;
         O_WB_DAT <= wb_req ? rdata : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         gh <= 1'b0;
         gl <= 1'b0;
         ple <= 1'b0;
         edge_sel <= `ICT_RST_EDGE;
         mvec <= `ICT_RST_MVEC;
      end else begin
         if (wr_ctl0) begin
            gh <= I_WB_DAT[`ICT_BIT_GH];
            gl <= I_WB_DAT[`ICT_BIT_GL];
            ple <= I_WB_DAT[`ICT_BIT_PLE];
            edge_sel <= I_WB_DAT[2:0];
         end
         if (wr_mode) begin
            mvec <= I_WB_DAT[`ICT_BIT_MVEC];
         end
      end
   end

   // Base, enables and priorities; priorities start all high
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         vtb <= `ICT_RST_VTB;
         ena <= '0;
         prio <= '1;
      end else begin
         if (wr_vtb) vtb <= w_vtb[20:0];
         if (wr_ena) ena <= w_ena[NSRC-1:0];
         if (wr_prio) prio <= w_prio[NSRC-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Event capture
   // ---------------------------------------------------------------
   logic [NEXT-1:0] ext_evt;

   ict_edge_det #(
      .N(NEXT)
   ) u_edge (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_pin(I_EXT_IRQ_PIN),
      .i_rise_sel(edge_sel),
      .o_edge(ext_evt)
   );

   wire [NSRC-1:0] set_evt = I_SRC_EVENT |
                             {{(NSRC-NEXT){1'b0}}, ext_evt};
   wire [NSRC-1:0] clr_msk = wr_flag ? w_clr[NSRC-1:0] : '0;

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         flag <= '0;
      end else begin
         flag <= (flag & ~clr_msk) | set_evt;
      end
   end

   // ---------------------------------------------------------------
   // Priority resolution
   // ---------------------------------------------------------------
   // Levels off makes every source high priority
   wire [NSRC-1:0] eff_high = ple ? prio : '1;
   wire [NSRC-1:0] pend = flag & ena;
   wire [NSRC-1:0] hp = pend & eff_high;
   wire [NSRC-1:0] lp = pend & ~eff_high;
   logic hp_any;
   logic lp_any;
   logic [4:0] hp_idx;
   logic [4:0] lp_idx;

   ict_prio_pick #(
      .N(NSRC)
   ) u_pick_high (
      .i_req(hp),
      .o_any(hp_any),
      .o_idx(hp_idx)
   );

   ict_prio_pick #(
      .N(NSRC)
   ) u_pick_low (
      .i_req(lp),
      .o_any(lp_any),
      .o_idx(lp_idx)
   );

   // ---------------------------------------------------------------
   // Nesting state
   // ---------------------------------------------------------------
   always_comb begin
      next_nest = nest;
      case (nest)
         ICT_MAIN: begin
            if (I_CPU_ENTER && O_IRQ_HIGH) next_nest = ICT_HIGH;
            else if (I_CPU_ENTER && O_IRQ_LOW) next_nest = ICT_LOW;
         end
         ICT_LOW: begin
            if (I_CPU_ENTER && O_IRQ_HIGH) begin
               next_nest = ICT_HIGH_OVER_LOW;
            end else if (I_CPU_RETURN) begin
               next_nest = ICT_MAIN;
            end
         end
         ICT_HIGH: begin
            if (I_CPU_RETURN) next_nest = ICT_MAIN;
         end
         ICT_HIGH_OVER_LOW: begin
            if (I_CPU_RETURN) next_nest = ICT_LOW;
         end
         default: next_nest = ICT_MAIN;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         nest <= ICT_MAIN;
      end else begin
         nest <= next_nest;
      end
   end

   // High may preempt low but never another high
   wire high_room = (next_nest == ICT_MAIN) || (next_nest == ICT_LOW);
   wire next_high = gh & hp_any & high_room;
   // Low also needs global high, and loses to any high
   wire next_low = gh & gl & ple & lp_any &
                   (next_nest == ICT_MAIN) & ~next_high;
   wire [4:0] next_num = next_high ? hp_idx : lp_idx;
   // Fixed branch when table is off; one address when levels off
   wire [20:0] fixed_addr = (next_high || !ple) ?
                            `ICT_FIXED_HIGH : `ICT_FIXED_LOW;
   wire [20:0] next_addr = mvec ? vtb + {16'h0000, next_num} :
                           fixed_addr;

   // Requests are recomputed from the state that follows this edge
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_IRQ_HIGH <= 1'b0;
         O_IRQ_LOW <= 1'b0;
         O_VECTOR_NUM <= 5'h00;
         O_VECTOR_ADDR <= 21'h00_0000;
      end else begin
         O_IRQ_HIGH <= next_high;
         O_IRQ_LOW <= next_low;
         O_VECTOR_NUM <= next_num;
         O_VECTOR_ADDR <= next_addr;
      end
   end

   // Wake is a pure gate of held flags, so it works with clocks off
   assign O_WAKE = |pend;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic prio_seen;
   logic vtb_seen;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         prio_seen <= 1'b0;
         vtb_seen <= 1'b0;
      end else begin
         prio_seen <= prio_seen | wr_prio;
         vtb_seen <= vtb_seen | wr_vtb;
      end
   end

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_N);

   a_prio_reset_high: assert property (
      !prio_seen |-> prio == '1)
      else $error("priority select left high state unwritten");
   a_base_default: assert property (
      !vtb_seen |-> vtb == `ICT_RST_VTB)
      else $error("vector base lost its default");
   a_ext_flag_set: assert property (
      |ext_evt |=> ((flag[2:0] & $past(ext_evt)) == $past(ext_evt)))
      else $error("external edge did not set its flag");
   a_wake_on_edge: assert property (
      (|(ext_evt & ena[2:0])) && !wr_ena |=> O_WAKE)
      else $error("enabled event gave no wake");
   a_global_block: assert property (
      !gh |=> !O_IRQ_HIGH && !O_IRQ_LOW)
      else $error("request with global enable clear");
   a_low_gate: assert property (
      !(gl && ple) |=> !O_IRQ_LOW)
      else $error("low request without low enable and levels");
   a_fixed_addr: assert property (
      O_IRQ_HIGH && !$past(mvec) && !$past(ple) |->
      O_VECTOR_ADDR == `ICT_FIXED_HIGH)
      else $error("compatibility branch not at fixed address");
   a_vector_sum: assert property (
      (O_IRQ_HIGH || O_IRQ_LOW) && $past(mvec) |->
      O_VECTOR_ADDR == $past(vtb) + {16'h0000, O_VECTOR_NUM})
      else $error("vector address is not base plus number");
   a_high_first: assert property (
      hp_any && gh && nest == ICT_MAIN && !I_CPU_ENTER |=> !O_IRQ_LOW)
      else $error("low request issued over pending high");
   a_nest_over_low: assert property (
      nest == ICT_HIGH_OVER_LOW |->
      $past(nest) == ICT_LOW || $past(nest) == ICT_HIGH_OVER_LOW)
      else $error("high over low state entered from wrong state");

   c_preempt_low: cover property (
      nest == ICT_LOW ##1 nest == ICT_HIGH_OVER_LOW);
   c_low_served: cover property (
      O_IRQ_LOW && I_CPU_ENTER ##1 nest == ICT_LOW);
   c_fixed_branch: cover property (
      O_IRQ_HIGH && O_VECTOR_ADDR == `ICT_FIXED_HIGH);
   c_wake_idle: cover property (O_WAKE && !gh);
endmodule : ict_top

// ==== test/ict_cpu_model.sv ====
`timescale 1ns/1ps
// -----------------------------
// CPU side: takes requests, returns on command
// -----------------------------
module ict_cpu_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_allow,
   input wire logic i_ret,
   input wire logic [1:0] i_delay,
   input wire logic i_irq_high,
   input wire logic i_irq_low,
   output logic o_enter,
   output logic o_return
);
   logic [1:0] hold;
   logic [1:0] cnt;
   // Hold stops a stale request from being taken twice
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_enter <= 1'b0;
         o_return <= 1'b0;
         hold <= 2'h0;
         cnt <= 2'h0;
      end else begin
         o_enter <= 1'b0;
         o_return <= 1'b0;
         if (hold != 2'h0) begin
            hold <= hold - 2'h1;
         end else if (i_ret) begin
            o_return <= 1'b1;
            hold <= 2'h3;
         end else if (i_allow && (i_irq_high || i_irq_low)) begin
            // Slow answers come from a nonzero delay
            if (cnt == i_delay) begin
               o_enter <= 1'b1;
               hold <= 2'h3;
               cnt <= 2'h0;
            end else begin
               cnt <= cnt + 2'h1;
            end
         end else begin
            cnt <= 2'h0;
         end
      end
   end
endmodule : ict_cpu_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "ict_cfg.svh"
module tb;
   typedef struct {string name; logic [31:0] exp;} ict_note_t;
   logic clk, rst_n, cyc, stb, we, ack, snap;
   logic [13:0] adr;
   logic [3:0] sel, msk;
   logic [31:0] wdat, rdat, seed, tmp, dum;
   logic [2:0] pin;
   logic [7:0] sev;
   logic enter, ret, allow, ret_req, irq_h, irq_l, wake;
   logic [1:0] dly;
   logic [4:0] vnum;
   logic [20:0] vaddr, base;
   int n_fail, samples_checked;
   ict_note_t q[$];
   // -----------------------------
   // Clock, design and CPU model
   // -----------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ict_top i_ict_top (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
      .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_EXT_IRQ_PIN(pin), .I_SRC_EVENT(sev), .I_CPU_ENTER(enter),
      .I_CPU_RETURN(ret), .O_IRQ_HIGH(irq_h), .O_IRQ_LOW(irq_l),
      .O_VECTOR_NUM(vnum), .O_VECTOR_ADDR(vaddr), .O_WAKE(wake));
   ict_cpu_model i_ict_cpu_model (.i_clk(clk), .i_rst_n(rst_n),
      .i_allow(allow), .i_ret(ret_req), .i_delay(dly),
      .i_irq_high(irq_h), .i_irq_low(irq_l), .o_enter(enter),
      .o_return(ret));
   // -----------------------------
   // Checking and closing
   // -----------------------------
   task automatic chk(input string nm, input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done
   // Random source for base and CPU delay
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xorshift = v ^ (v << 5);
   endfunction : xorshift
   // Vector fields mean nothing while no request stands
   always @(posedge clk) begin : mon
      ict_note_t n;
      logic [31:0] g;
      if (cyc && ack && !we) begin
         n = q.pop_front();
         chk(n.name, rdat, n.exp);
      end
      if (snap) begin
         n = q.pop_front();
         g = {3'h0, wake, irq_h, irq_l, vnum, vaddr};
         if (!n.exp[27] && !n.exp[26]) g[25:0] = n.exp[25:0];
         chk(n.name, g, n.exp);
      end
   end
   // -----------------------------
   // Drivers
   // -----------------------------
   task automatic wb(input logic w, input logic [11:0] idx,
      input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= d;
      sel <= msk;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (!ack && k < 50);
      if (!ack) begin
         n_fail++;
         test_done();
      end
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      wb(1'b1, idx, d, dum);
   endtask : wr
   task automatic rd(input logic [11:0] idx, input logic [31:0] e,
      input string nm);
      q.push_back('{nm, e});
      wb(1'b0, idx, 32'h0000_0000, dum);
   endtask : rd
   task automatic snp(input logic w, h, l, input logic [4:0] n,
      input logic [20:0] a, input string nm);
      q.push_back('{nm, {3'h0, w, h, l, n, a}});
      repeat (2) @(posedge clk);
      snap <= 1'b1;
      @(posedge clk);
      snap <= 1'b0;
   endtask : snp
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      sev <= m;
      @(posedge clk);
      sev <= 8'h00;
      repeat (10) @(posedge clk);
   endtask : pulse
   task automatic back();
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      repeat (12) @(posedge clk);
   endtask : back
   task automatic pins(input logic [2:0] v);
      @(posedge clk);
      pin <= v;
      repeat (8) @(posedge clk);
   endtask : pins
   // -----------------------------
   // Main sequence
   // -----------------------------
   initial begin
      {rst_n, cyc, stb, we, snap, allow, ret_req} = 7'h00;
      {adr, sel, wdat, pin, sev, dly} = '0;
      n_fail = 0;
      samples_checked = 0;
      seed = 32'h8b53_fd17;
      msk = 4'hf;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(`ICT_IDX_CTL0, 32'h0000_0007, "ctl0 reset");
      rd(`ICT_IDX_CTL1, 32'h0000_0000, "nest reset");
      rd(`ICT_IDX_VTB, 32'h0000_0008, "base reset");
      rd(`ICT_IDX_PRIO, 32'h0000_00ff, "prio reset");
      wr(12'h0123, 32'hffff_ffff);
      rd(12'h0123, 32'h0000_0000, "unmapped");
      wr(`ICT_IDX_CTL0, 32'h0000_0047);
      rd(`ICT_IDX_CTL0, 32'h0000_0007, "low enable hidden");
      // Byte lanes: control needs lane 0, base honours every lane
      msk = 4'he;
      wr(`ICT_IDX_CTL0, 32'h0000_00ff);
      msk = 4'h1;
      wr(`ICT_IDX_VTB, 32'hffff_ffff);
      msk = 4'hf;
      rd(`ICT_IDX_CTL0, 32'h0000_0007, "ctl0 lane ignored");
      rd(`ICT_IDX_VTB, 32'h0000_00ff, "base lane write");
      $display("test registers done");
      // Compatibility mode, software order kept
      wr(`ICT_IDX_MODE, 32'h0000_0000);
      wr(`ICT_IDX_PRIO, 32'h0000_00df);
      wr(`ICT_IDX_FLAG, 32'h0000_00ff);
      wr(`ICT_IDX_ENA, 32'h0000_0020);
      wr(`ICT_IDX_CTL0, 32'h0000_0087);
      pulse(8'h20);
      snp(1, 1, 0, 5'd5, 21'h00_0008, "fixed vector");
      wr(`ICT_IDX_CTL0, 32'h0000_0007);
      snp(1, 0, 0, 5'd0, 21'h0, "global off wake");
      wr(`ICT_IDX_ENA, 32'h0000_0000);
      snp(0, 0, 0, 5'd0, 21'h0, "disabled no wake");
      $display("test compatibility done");
      // Levels and table, random base and CPU delay
      seed = xorshift(seed);
      tmp = seed;
      base = tmp[20:0];
      dly = tmp[31:30];
      wr(`ICT_IDX_CTL0, 32'h0000_0027);
      wr(`ICT_IDX_PRIO, 32'h0000_00df);
      wr(`ICT_IDX_FLAG, 32'h0000_00ff);
      wr(`ICT_IDX_ENA, 32'h0000_0060);
      wr(`ICT_IDX_MODE, 32'h0000_0001);
      wr(`ICT_IDX_VTB, {11'h0, base});
      rd(`ICT_IDX_VTB, {11'h0, base}, "base write");
      wr(`ICT_IDX_CTL0, 32'h0000_00a7);
      pulse(8'h20);
      snp(1, 0, 0, 5'd0, 21'h0, "low gated");
      wr(`ICT_IDX_CTL0, 32'h0000_00e7);
      snp(1, 0, 1, 5'd5, base + 21'd5, "table low");
      pulse(8'h40);
      snp(1, 1, 0, 5'd6, base + 21'd6, "high first");
      allow <= 1'b1;
      repeat (12) @(posedge clk);
      rd(`ICT_IDX_CTL1, 32'h0000_0080, "nest high");
      wr(`ICT_IDX_FLAG, 32'h0000_0040);
      back();
      rd(`ICT_IDX_CTL1, 32'h0000_0040, "nest low");
      pulse(8'h40);
      rd(`ICT_IDX_CTL1, 32'h0000_00c0, "nest preempt");
      wr(`ICT_IDX_FLAG, 32'h0000_0040);
      back();
      rd(`ICT_IDX_CTL1, 32'h0000_0040, "nest resume");
      wr(`ICT_IDX_FLAG, 32'h0000_0020);
      back();
      rd(`ICT_IDX_CTL1, 32'h0000_0000, "nest main");
      allow <= 1'b0;
      $display("test nesting done");
      // External pins, both polarities, wrong edge ignored
      for (int p = 0; p < 2; p++) begin
         wr(`ICT_IDX_CTL0, (p == 0) ? 32'h0000_0007 : 32'h0000_0000);
         pins((p == 0) ? 3'h0 : 3'h7);
         wr(`ICT_IDX_FLAG, 32'h0000_00ff);
         for (int i = 0; i < 3; i++) begin
            pins(pin ^ (3'h1 << i));
            rd(`ICT_IDX_FLAG, 32'h1 << i, "edge flag");
            pins(pin ^ (3'h1 << i));
            rd(`ICT_IDX_FLAG, 32'h1 << i, "wrong edge");
            wr(`ICT_IDX_FLAG, 32'h1 << i);
         end
      end
      wr(`ICT_IDX_PRIO, 32'h0000_00fd);
      wr(`ICT_IDX_ENA, 32'h0000_0002);
      wr(`ICT_IDX_CTL0, 32'h0000_00e0);
      pins(3'h5);
      snp(1, 0, 1, 5'd1, base + 21'd1, "pin priority");
      $display("test pins done");
      test_done();
   end
endmodule : tb
